/* hw/four_rail_power_sequencer.sv */
// How it works
// - four rails, each gate, monitor, timer
// - enable starts on, disable starts off
// - enable ignored 10ms after rails good
// - 10ms wait, then per-rail on timers
// - done rises 160ms after all gates on
// - done drops on fault or disable
// - monitor dips under 7us ignored
// - done driven only from filtered inputs
// - all rails good before and during run
// - enable polarity fixed by build parameter
// - active-high build idles in standby
// - shared line chains several sequencers
// - line low kills gates; fault pulls low
// - per-rail off timers switch gates off
// - line released on enable, low at end
`timescale 1ns/1ps
`include "seq_consts.svh"

module four_rail_power_sequencer
#(
   parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
   parameter int SETTLE_CYC         = `PS_SETTLE_CYC,
   parameter int STABLE_CYC         = `PS_STABLE_CYC
)
(
   input  wire logic           clk_in,
   input  wire logic           rst_b_in,
   input  wire logic           enable_in,
   input  wire logic           rail_a_undervolt_in,
   input  wire logic           rail_b_undervolt_in,
   input  wire logic           rail_c_undervolt_in,
   input  wire logic           rail_d_undervolt_in,
   input  wire seq_pkg::delay_t rail_a_on_delay_in,
   input  wire seq_pkg::delay_t rail_b_on_delay_in,
   input  wire seq_pkg::delay_t rail_c_on_delay_in,
   input  wire seq_pkg::delay_t rail_d_on_delay_in,
   input  wire seq_pkg::delay_t rail_a_off_delay_in,
   input  wire seq_pkg::delay_t rail_b_off_delay_in,
   input  wire seq_pkg::delay_t rail_c_off_delay_in,
   input  wire seq_pkg::delay_t rail_d_off_delay_in,
   input  wire logic           latchoff_line_in,
   output logic                latchoff_line_out,
   output logic                latchoff_line_oe_out,
   output logic                rail_a_gate_out,
   output logic                rail_b_gate_out,
   output logic                rail_c_gate_out,
   output logic                rail_d_gate_out,
   output logic                seq_done_out,
   output logic                standby_out
);
   import seq_pkg::*;

   localparam int N = `PS_NUM_RAILS;

   logic [N-1:0]          uv_pins;
   logic [N-1:0]          uv_vec;
   logic [N-1:0]          gate_vec;
   logic [N-1:0]          gate_next_vec;
   delay_t                on_dly [N];
   delay_t                off_dly [N];
   logic [`PS_SYNC_W-1:0] en_sync;
   logic [`PS_SYNC_W-1:0] next_en_sync;
   logic [`PS_SYNC_W-1:0] line_sync;
   logic [`PS_SYNC_W-1:0] next_line_sync;
   logic                  en_lvl;
   logic                  next_en_lvl;
   logic [`PS_AGE_W-1:0]  rel_age;
   logic [`PS_AGE_W-1:0]  next_rel_age;
   seq_state_t            state;
   seq_state_t            next_state;
   logic [`PS_TMR_W-1:0]  tmr;
   logic [`PS_TMR_W-1:0]  next_tmr;
   logic                  next_line_oe;
   logic                  next_done;
   logic                  next_standby;
   logic                  enabled;
   logic                  uv_any;
   logic                  ext_kill;
   logic                  start_on;
   logic                  start_off;
   logic                  kill;

   assign uv_pins = {rail_d_undervolt_in, rail_c_undervolt_in,
                     rail_b_undervolt_in, rail_a_undervolt_in};
   assign on_dly  = '{rail_a_on_delay_in, rail_b_on_delay_in,
                      rail_c_on_delay_in, rail_d_on_delay_in};
   assign off_dly = '{rail_a_off_delay_in, rail_b_off_delay_in,
                      rail_c_off_delay_in, rail_d_off_delay_in};

   rail_chan_if ch_if [N] ();

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_rail
         assign ch_if[i].start_on  = start_on;
         assign ch_if[i].start_off = start_off;
         assign ch_if[i].kill      = kill;
         assign ch_if[i].on_delay  = on_dly[i];
         assign ch_if[i].off_delay = off_dly[i];
         assign uv_vec[i]          = ch_if[i].uv_fault;
         assign gate_vec[i]        = ch_if[i].gate;
         assign gate_next_vec[i]   = ch_if[i].gate_next;
         rail_channel u_rail
         (
            .clk_in    (clk_in),
            .rst_b_in  (rst_b_in),
            .uv_pin_in (uv_pins[i]),
            .ch        (ch_if[i])
         );
      end
   endgenerate

   assign rail_a_gate_out = gate_vec[0];
   assign rail_b_gate_out = gate_vec[1];
   assign rail_c_gate_out = gate_vec[2];
   assign rail_d_gate_out = gate_vec[3];

   // own release shows on the synchroniser only a few edges later, so an
   // outside pull is believed only once the release has aged
   always_comb
   begin
      next_en_sync   = {en_sync[1:0], enable_in};
      next_line_sync = {line_sync[1:0], latchoff_line_in};
      next_en_lvl    = en_lvl;
      if (en_sync[1] == en_sync[2])
         next_en_lvl = en_sync[2];
      next_rel_age = rel_age;
      if (latchoff_line_oe_out)
         next_rel_age = '0;
      else if (rel_age != `PS_AGE_MAX)
         next_rel_age = rel_age + 1'b1;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         en_sync   <= {`PS_SYNC_W{~ENABLE_ACTIVE_HIGH}};
         line_sync <= '0;
         en_lvl    <= ~ENABLE_ACTIVE_HIGH;
         rel_age   <= '0;
      end
      else
      begin
         en_sync   <= next_en_sync;
         line_sync <= next_line_sync;
         en_lvl    <= next_en_lvl;
         rel_age   <= next_rel_age;
      end
   end

   assign enabled  = ENABLE_ACTIVE_HIGH ? en_lvl : ~en_lvl;
   assign uv_any   = |uv_vec;
   assign ext_kill = ~line_sync[1] & ~line_sync[2] & ~latchoff_line_oe_out
                     & (rel_age == `PS_AGE_MAX);

   always_comb
   begin
      next_state = state;
      next_tmr   = tmr;
      start_on   = 1'b0;
      start_off  = 1'b0;
      kill       = 1'b0;
      case (state)
         ST_LOCKOUT:
         begin
            next_tmr = '0;
            if (!uv_any)
               next_state = ST_SETTLE;
         end
         ST_SETTLE:
         begin
            if (uv_any)
               next_state = ST_LOCKOUT;
            else if (tmr == `PS_TMR_W'(SETTLE_CYC - 1))
            begin
               next_state = ST_IDLE;
               next_tmr   = '0;
            end
            else
               next_tmr = tmr + 1'b1;
         end
         ST_IDLE:
         begin
            next_tmr = '0;
            if (enabled)
               next_state = ST_PRE_ON;
         end
         ST_PRE_ON:
         begin
            if (!enabled)
               next_state = ST_IDLE;
            else if (tmr == `PS_TMR_W'(SETTLE_CYC - 1))
            begin
               next_state = ST_ON_RUN;
               start_on   = 1'b1;
            end
            else
               next_tmr = tmr + 1'b1;
         end
         ST_ON_RUN, ST_STABLE, ST_DONE:
         begin
            if (!enabled)
            begin
               next_state = ST_OFF_RUN;
               start_off  = 1'b1;
            end
            else if (state == ST_ON_RUN && &gate_vec)
            begin
               next_state = ST_STABLE;
               next_tmr   = '0;
            end
            else if (state == ST_STABLE)
            begin
               if (tmr == `PS_TMR_W'(STABLE_CYC - 1))
                  next_state = ST_DONE;
               else
                  next_tmr = tmr + 1'b1;
            end
         end
         ST_OFF_RUN:
         begin
            // a new enable waits until the off sequence has finished
            if (~|gate_next_vec)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_LOCKOUT;
      endcase
      if ((uv_any || ext_kill) && state != ST_LOCKOUT && state != ST_SETTLE)
      begin
         kill       = 1'b1;
         start_on   = 1'b0;
         start_off  = 1'b0;
         next_state = ST_LOCKOUT;
      end
      next_line_oe = next_state == ST_LOCKOUT || next_state == ST_SETTLE
                     || next_state == ST_IDLE;
      next_done    = next_state == ST_DONE;
      next_standby = ENABLE_ACTIVE_HIGH && next_state == ST_IDLE;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state                <= ST_LOCKOUT;
         tmr                  <= '0;
         latchoff_line_out    <= 1'b0;
         latchoff_line_oe_out <= 1'b1;
         seq_done_out         <= 1'b0;
         standby_out          <= 1'b0;
      end
      else
      begin
         state                <= next_state;
         tmr                  <= next_tmr;
         latchoff_line_out    <= 1'b0;
         latchoff_line_oe_out <= next_line_oe;
         seq_done_out         <= next_done;
         standby_out          <= next_standby;
      end
   end

   a_kill_gates_off: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) kill |=> gate_vec == '0 && !seq_done_out)
      else $error("gates not latched off after kill");
   a_done_on_fault: assert property (@(posedge clk_in)
      disable iff (!rst_b_in)
      uv_any || (!enabled && state != ST_OFF_RUN) |=> !seq_done_out)
      else $error("sequence done held during fault or disable");
   a_done_after_on: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) $rose(seq_done_out)
      |-> $past(state) == ST_STABLE && $past(gate_vec) == '1)
      else $error("sequence done rose without all gates on");
   a_settle_ignores_en: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) state == ST_SETTLE |=> state != ST_PRE_ON)
      else $error("enable acted on during settling");
   a_pre_on_wait: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) $rose(state == ST_PRE_ON) |-> !start_on [*4])
      else $error("on timers started without the wait");
   a_fault_pulls_line: assert property (@(posedge clk_in)
      disable iff (!rst_b_in)
      uv_any |=> latchoff_line_oe_out && gate_vec == '0)
      else $error("line not pulled low on undervolt");
   a_line_with_last: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) state == ST_OFF_RUN && gate_vec != '0
      |=> latchoff_line_oe_out == (gate_vec == '0))
      else $error("line not pulled with the last gate off");
   a_standby_idle: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) state == ST_IDLE ##1 state == ST_IDLE
      |-> standby_out == ENABLE_ACTIVE_HIGH)
      else $error("standby does not follow the disabled state");
endmodule

/* hw/rail_chan_if.sv */
`timescale 1ns/1ps

interface rail_chan_if;
   import seq_pkg::*;

   logic   start_on;
   logic   start_off;
   logic   kill;
   delay_t on_delay;
   delay_t off_delay;
   logic   uv_fault;
   logic   gate;
   logic   gate_next;

   modport ctrl
   (
      output start_on, start_off, kill, on_delay, off_delay,
      input  uv_fault, gate, gate_next
   );

   modport chan
   (
      input  start_on, start_off, kill, on_delay, off_delay,
      output uv_fault, gate, gate_next
   );
endinterface

/* hw/rail_channel.sv */
`timescale 1ns/1ps
`include "seq_consts.svh"

module rail_channel
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic uv_pin_in,
   rail_chan_if.chan ch
);
   import seq_pkg::*;

   logic [`PS_SYNC_W-1:0] uv_sync;
   logic [`PS_SYNC_W-1:0] next_uv_sync;
   logic [`PS_FILT_W-1:0] filt_cnt;
   logic [`PS_FILT_W-1:0] next_filt_cnt;
   logic                  uv_fault;
   logic                  next_uv_fault;
   logic                  lvl_bad;
   logic                  lvl_good;
   chan_mode_t            mode;
   chan_mode_t            next_mode;
   delay_t                cnt;
   delay_t                next_cnt;
   logic                  gate;
   logic                  next_gate;

   // short dips never reach the sequencer; recovery is taken at once
   always_comb
   begin
      next_uv_sync  = {uv_sync[1:0], uv_pin_in};
      lvl_bad       = uv_sync[1] & uv_sync[2];
      lvl_good      = ~uv_sync[1] & ~uv_sync[2];
      next_filt_cnt = filt_cnt;
      next_uv_fault = uv_fault;
      if (lvl_good)
      begin
         next_filt_cnt = '0;
         next_uv_fault = 1'b0;
      end
      else if (lvl_bad && !uv_fault)
      begin
         if (filt_cnt == `PS_FILT_W'(`PS_UV_FILT_CYC - 1))
            next_uv_fault = 1'b1;
         else
            next_filt_cnt = filt_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         uv_sync  <= '0;
         filt_cnt <= '0;
         uv_fault <= 1'b0;
      end
      else
      begin
         uv_sync  <= next_uv_sync;
         filt_cnt <= next_filt_cnt;
         uv_fault <= next_uv_fault;
      end
   end

   always_comb
   begin
      next_mode = mode;
      next_cnt  = cnt;
      next_gate = gate;
      if (ch.kill)
      begin
         next_mode = CH_HOLD;
         next_gate = 1'b0;
      end
      else if (ch.start_on)
      begin
         next_mode = CH_ON_WAIT;
         next_cnt  = '0;
      end
      else if (ch.start_off)
      begin
         next_mode = CH_OFF_WAIT;
         next_cnt  = '0;
      end
      else
      begin
         case (mode)
            CH_ON_WAIT:
            begin
               if (cnt == ch.on_delay)
               begin
                  next_gate = 1'b1;
                  next_mode = CH_HOLD;
               end
               else
                  next_cnt = cnt + 1'b1;
            end
            CH_OFF_WAIT:
            begin
               if (cnt == ch.off_delay)
               begin
                  next_gate = 1'b0;
                  next_mode = CH_HOLD;
               end
               else
                  next_cnt = cnt + 1'b1;
            end
            default:
               next_mode = CH_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         mode <= CH_HOLD;
         cnt  <= '0;
         gate <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         cnt  <= next_cnt;
         gate <= next_gate;
      end
   end

   assign ch.uv_fault  = uv_fault;
   assign ch.gate      = gate;
   assign ch.gate_next = next_gate;

   a_uv_filter_len: assert property (@(posedge clk_in)
      disable iff (!rst_b_in)
      $rose(uv_fault) |-> $past(lvl_bad, 1) && $past(lvl_bad, 8))
      else $error("undervolt fault without a sustained dip");

   a_gate_off_timer: assert property (@(posedge clk_in)
      disable iff (!rst_b_in)
      $fell(gate) && !$past(ch.kill) |-> $past(mode) == CH_OFF_WAIT)
      else $error("gate dropped outside its off delay");

   a_gate_on_timer: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) $rose(gate)
      |-> $past(mode) == CH_ON_WAIT && $past(cnt) == $past(ch.on_delay))
      else $error("gate rose before its on delay expired");
endmodule

/* hw/seq_consts.svh */
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define PS_NUM_RAILS    4
`define PS_CLK_NS       40
`define PS_CLK_KHZ      25000
`define PS_SETTLE_MS    10
`define PS_SETTLE_CYC   (`PS_SETTLE_MS * `PS_CLK_KHZ)
`define PS_STABLE_MS    160
`define PS_STABLE_CYC   (`PS_STABLE_MS * `PS_CLK_KHZ)
`define PS_UV_FILT_NS   7000
`define PS_UV_FILT_CYC  ((`PS_UV_FILT_NS + `PS_CLK_NS - 1) / `PS_CLK_NS)
`define PS_TMR_W        23
`define PS_DLY_W        24
`define PS_FILT_W       8
`define PS_AGE_W        2
`define PS_AGE_MAX      2'h3
`define PS_SYNC_W       3

`endif

/* hw/seq_pkg.sv */
`include "seq_consts.svh"

package seq_pkg;

   typedef logic [`PS_DLY_W-1:0] delay_t;

   typedef enum logic [2:0]
   {
      ST_LOCKOUT,
      ST_SETTLE,
      ST_IDLE,
      ST_PRE_ON,
      ST_ON_RUN,
      ST_STABLE,
      ST_DONE,
      ST_OFF_RUN
   } seq_state_t;

   typedef enum logic [1:0]
   {
      CH_HOLD,
      CH_ON_WAIT,
      CH_OFF_WAIT
   } chan_mode_t;

endpackage

/* tb/four_rail_power_sequencer_tb.sv */
`timescale 1ns/1ps

`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         err_total++; \
         $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
      end \
   end

module four_rail_power_sequencer_tb;
   import seq_pkg::*;

   localparam int SETTLE = 8;
   localparam int STABLE = 10;

   typedef struct
   {
      logic [4:0] v;
      int         lo;
      int         hi;
   } note_t;

   logic           clk;
   logic           rst_b;
   logic           en;
   logic     [3:0] uv_req;
   logic           pull;
   logic     [3:0] uv_pin;
   logic           line;
   logic     [1:0] oe;
   logic     [1:0] drv;
   logic     [3:0] gates;
   logic     [3:0] gates_b;
   logic           done;
   logic           done_b;
   logic           standby;
   logic           standby_b;
   delay_t         on_d [4];
   delay_t         off_d [4];
   note_t          q [$];
   int             err_total;
   int             checked;
   int             gap;
   logic     [4:0] prev;

   rail_supply_model i_rail_supply_model
   (
      .uv_req_in   (uv_req),
      .pull_req_in (pull),
      .oe_in       (oe),
      .uv_pin_out  (uv_pin),
      .line_out    (line)
   );

   four_rail_power_sequencer
   #(
      .ENABLE_ACTIVE_HIGH (1'b1),
      .SETTLE_CYC         (SETTLE),
      .STABLE_CYC         (STABLE)
   )
   i_four_rail_power_sequencer
   (
      .clk_in (clk), .rst_b_in (rst_b), .enable_in (en),
      .rail_a_undervolt_in (uv_pin[0]), .rail_b_undervolt_in (uv_pin[1]),
      .rail_c_undervolt_in (uv_pin[2]), .rail_d_undervolt_in (uv_pin[3]),
      .rail_a_on_delay_in (on_d[0]), .rail_b_on_delay_in (on_d[1]),
      .rail_c_on_delay_in (on_d[2]), .rail_d_on_delay_in (on_d[3]),
      .rail_a_off_delay_in (off_d[0]), .rail_b_off_delay_in (off_d[1]),
      .rail_c_off_delay_in (off_d[2]), .rail_d_off_delay_in (off_d[3]),
      .latchoff_line_in (line), .latchoff_line_out (drv[0]),
      .latchoff_line_oe_out (oe[0]),
      .rail_a_gate_out (gates[0]), .rail_b_gate_out (gates[1]),
      .rail_c_gate_out (gates[2]), .rail_d_gate_out (gates[3]),
      .seq_done_out (done), .standby_out (standby)
   );

   // second device of the opposite enable polarity chained on the same line
   four_rail_power_sequencer
   #(
      .ENABLE_ACTIVE_HIGH (1'b0),
      .SETTLE_CYC         (SETTLE),
      .STABLE_CYC         (STABLE)
   )
   i_four_rail_power_sequencer_b
   (
      .clk_in (clk), .rst_b_in (rst_b), .enable_in (~en),
      .rail_a_undervolt_in (uv_pin[0]), .rail_b_undervolt_in (uv_pin[1]),
      .rail_c_undervolt_in (uv_pin[2]), .rail_d_undervolt_in (uv_pin[3]),
      .rail_a_on_delay_in (on_d[0]), .rail_b_on_delay_in (on_d[1]),
      .rail_c_on_delay_in (on_d[2]), .rail_d_on_delay_in (on_d[3]),
      .rail_a_off_delay_in (off_d[0]), .rail_b_off_delay_in (off_d[1]),
      .rail_c_off_delay_in (off_d[2]), .rail_d_off_delay_in (off_d[3]),
      .latchoff_line_in (line), .latchoff_line_out (drv[1]),
      .latchoff_line_oe_out (oe[1]),
      .rail_a_gate_out (gates_b[0]), .rail_b_gate_out (gates_b[1]),
      .rail_c_gate_out (gates_b[2]), .rail_d_gate_out (gates_b[3]),
      .seq_done_out (done_b), .standby_out (standby_b)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic add(input logic [4:0] v, input int lo, input int hi);
      note_t n;
      n.v = v;
      n.lo = lo;
      n.hi = hi;
      q.push_back(n);
   endtask

   // gates share one timer start, so their spacing is the delay difference
   task automatic push_seq(input bit on, input int first_lo);
      logic [4:0] v;
      int         pt;
      bit         first;
      v = on ? 5'h00 : 5'h1e;
      pt = 0;
      first = 1'b1;
      if (!on)
         add(v, 0, 5000);
      for (int t = 0; t < 64; t++)
         for (int i = 0; i < 4; i++)
            if ((on ? on_d[i] : off_d[i]) == t)
            begin
               v[i+1] = on;
               add(v, first ? first_lo : t - pt, first ? 5000 : t - pt);
               pt = t;
               first = 1'b0;
            end
      if (on)
         add(v | 5'h01, STABLE, STABLE + 2);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wait_q();
      int n;
      n = 0;
      while (q.size() != 0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (q.size() != 0)
      begin
         err_total++;
         $display("[ERR] wait for outputs timed out");
         end_of_test();
      end
      repeat (3) @(posedge clk);
      #2;
   endtask

   // watcher: every change of gates or done must match the oldest note
   always @(posedge clk)
   begin
      if (rst_b && {gates, done} !== prev)
      begin
         if (q.size() == 0)
            `CHK("unexpected change", prev, {gates, done})
         else
         begin
            `CHK("gates and done", q[0].v, {gates, done})
            `CHK("change gap", 1'b1, gap >= q[0].lo && gap <= q[0].hi)
            void'(q.pop_front());
         end
         gap = 1;
      end
      else
         gap++;
      prev = {gates, done};
   end

   always @(posedge clk)
      if (rst_b)
      begin
         `CHK("mirror gates", gates, gates_b)
         `CHK("low build standby", 1'b0, standby_b)
         `CHK("mirror done", done, done_b)
         `CHK("line drive value", 2'h0, drv)
      end

   initial
   begin
      rst_b = 1'b0;
      en = 1'b0;
      uv_req = 4'h0;
      pull = 1'b0;
      err_total = 0;
      checked = 0;
      gap = 0;
      prev = 5'h00;
      void'($urandom(34271));
      for (int i = 0; i < 4; i++)
      begin
         on_d[i] = delay_t'(($urandom % 10) * 4 + i);
         off_d[i] = delay_t'(($urandom % 10) * 4 + 3 - i);
      end
      repeat (6) @(posedge clk);
      #2;
      `CHK("reset gates", 4'h0, gates)
      `CHK("reset line pull", 1'b1, oe[0])
      rst_b = 1'b1;
      repeat (60) @(posedge clk);
      #2;
      `CHK("idle standby", 1'b1, standby)
      `CHK("idle line pull", 1'b1, oe[0])
      push_seq(1'b1, SETTLE);
      en = 1'b1;
      wait_q();
      `CHK("run line pull", 1'b0, oe[0])
      `CHK("run standby", 1'b0, standby)
      // dip shorter than the filter must leave everything as it is
      uv_req[1] = 1'b1;
      repeat (100) @(posedge clk);
      #2;
      uv_req[1] = 1'b0;
      repeat (30) @(posedge clk);
      #2;
      `CHK("done after short dip", 1'b1, done)
      // long dip: all off at once, enable held, restart only after settling
      add(5'h00, 0, 5000);
      push_seq(1'b1, SETTLE + 20);
      uv_req[2] = 1'b1;
      repeat (200) @(posedge clk);
      #2;
      `CHK("fault line pull", 1'b1, oe[0])
      uv_req[2] = 1'b0;
      wait_q();
      // another party pulls the shared line
      add(5'h00, 0, 5000);
      push_seq(1'b1, SETTLE + 8);
      pull = 1'b1;
      repeat (10) @(posedge clk);
      #2;
      pull = 1'b0;
      wait_q();
      push_seq(1'b0, 0);
      en = 1'b0;
      wait_q();
      `CHK("off line pull", 1'b1, oe[0])
      `CHK("off standby", 1'b1, standby)
      end_of_test();
   end
endmodule

/* tb/rail_supply_model.sv */
`timescale 1ns/1ps

module rail_supply_model
(
   input  wire logic [3:0] uv_req_in,
   input  wire logic       pull_req_in,
   input  wire logic [1:0] oe_in,
   output logic      [3:0] uv_pin_out,
   output logic            line_out
);
   // a rail under its threshold shows a high monitor pin
   assign uv_pin_out = uv_req_in;
   // open drain with pull-up: any party pulling wins over the resistor
   assign line_out = ~(pull_req_in | (|oe_in));
endmodule
